// ==== hw/rcr_core_regs.sv ====
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - sixteen 8-bit registers: r0-r3, index halves, flags word, accumulator.
// - register pairs combine into 16-bit values for wide operands.
// - four data indexes and program index built from high and low bytes.
// - 22-bit instruction holds one of 35 operations and 8 modes.
// - every instruction, jumps and multiply included, takes one cycle.
// - interrupt wakes from halt into handler; event resumes after halt.
// - 16-bit program counter holds the next instruction address.
// - return stack saves address on call and interrupt, restores on return.
// - flags bit 7 enables level-2 interrupts.
// - flags bit 6 enables level-1 interrupts.
// - flags bit 5 globally gates all interrupt levels.
// - bit 4 latches low priority interrupt requests.
// - bit 3 latches middle priority interrupt requests.
// - bit 2 latches high priority interrupt requests.
// - pending bits stay set until a write clears them.
// - bit 1 latches low priority events until software clears it.
// - bit 0 latches high priority events until software clears it.
// - zero flag is one when the last accumulator result the core wrote was zero.
// - shifts put the bit shifted out into carry.
// - carry set on add overflow, cleared on subtract underflow.
// - overflow flag set on signed range overflow or underflow.
// - select high gives 8k space; low gives 4k at double speed.
module rcr_core_regs (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// program memory
	output logic [rcr_pkg::WORD_W-1:0] program_counter,
	input wire rcr_pkg::rcr_instr_type instr,
	input wire logic instr_valid,
	input wire logic slow_fetch_select,
	output logic fast_fetch,
	// data memory
	output rcr_pkg::rcr_dmem_type dmem,
	input wire logic [rcr_pkg::DATA_W-1:0] dmem_rdata,
	// interrupt and event handlers
	input wire rcr_pkg::rcr_req_type req,
	// core state
	output logic halted,
	output logic illegal_op
);
	import rcr_pkg::*;

	logic [7:0] regs_r [NUM_REGS];
	logic [7:0] stat_r;
	logic [7:0] stat_nxt;
	logic [15:0] stack_r [STACK_DEPTH];
	logic [3:0] depth_r;
	logic [15:0] pc_r;
	logic [15:0] pc_nxt;
	logic [15:0] pc_mask;
	logic halted_r;
	logic halt_nxt;
	logic z_r;
	logic c_r;
	logic v_r;
	logic c_nxt;
	logic v_nxt;
	logic upd_z;
	logic illegal_r;
	logic fast_r;
	logic sel_meta_r;
	logic sel_sync_r;
	logic [31:0] prdata_r;
	rcr_op_type op;
	rcr_mode_type mode;
	logic is_mem;
	logic [15:0] i0_w;
	logic [15:0] i1_w;
	logic [15:0] i2_w;
	logic [15:0] i3_w;
	logic [15:0] ip_w;
	logic [15:0] eaddr;
	logic [15:0] jaddr;
	logic [15:0] pc_inc;
	logic [7:0] src;
	logic [7:0] op1;
	logic [7:0] res;
	logic [7:0] acc_val;
	logic [8:0] sum9;
	logic [15:0] prod;
	logic wr_r1;
	logic wr_acc;
	logic wr_ip;
	logic [15:0] ip_val;
	logic push;
	logic pop;
	logic [15:0] push_val;
	logic set_gie;
	logic dm_we;
	logic dm_re;
	logic take0;
	logic take1;
	logic take2;
	logic [1:0] take_lvl;
	logic irq_take;
	logic ev_wake;
	logic exec;
	logic op_bad;
	logic apb_hit;
	logic apb_wr;
	logic apb_reg_wr;
	logic apb_flag_wr;
	logic [31:0] rd_val;

	function automatic logic [7:0] reg_rd(input logic [3:0] idx);
		logic [7:0] val;
		val = (idx == REG_STAT) ? stat_r : regs_r[idx];
		return val;
	endfunction : reg_rd

	// two-stage catch of the fetch-speed pin
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sel_meta_r <= 1'b1;
			sel_sync_r <= 1'b1;
		end else begin
			sel_meta_r <= slow_fetch_select;
			sel_sync_r <= sel_meta_r;
		end
	end

	// a wrong select breaks fetches, so the space shrinks with it
	assign pc_mask = sel_sync_r ? FULL_PC_MASK : SHORT_PC_MASK;

	// wide views of the byte pairs
	assign i0_w = {regs_r[REG_I0H], regs_r[REG_I0L]};
	assign i1_w = {regs_r[REG_I1H], regs_r[REG_I1L]};
	assign i2_w = {regs_r[REG_I2H], regs_r[REG_I2L]};
	assign i3_w = {regs_r[REG_I3H], regs_r[REG_I3L]};
	assign ip_w = {regs_r[REG_IPH], regs_r[REG_IPL]};

	// instruction decode
	assign op = rcr_op_type'(instr.op);
	assign mode = rcr_mode_type'(instr.mode);
	assign op_bad = instr.op >= 6'(OP_COUNT);
	assign jaddr = {instr.spare, instr.mode, instr.r1, instr.data};
	assign pc_inc = pc_r + 16'h0001;
	assign is_mem = (mode != MD_IMM) && (mode != MD_REG);

	always_comb begin
		eaddr = {8'h00, instr.data};
		case (mode)
			MD_IDX0: eaddr = i0_w;
			MD_IDX1: eaddr = i1_w;
			MD_IDX2: eaddr = i2_w;
			MD_IDX3: eaddr = i3_w;
			MD_IDX0_OFS: eaddr = i0_w + {8'h00, regs_r[REG_DATA_OFS]};
			default: eaddr = {8'h00, instr.data};
		endcase
	end

	always_comb begin
		src = dmem_rdata;
		if (mode == MD_IMM) begin
			src = instr.data;
		end else if (mode == MD_REG) begin
			src = reg_rd(instr.data[3:0]);
		end
	end
	assign op1 = reg_rd(instr.r1);

	// interrupt selection
	assign take0 = stat_r[ST_GIE] && stat_r[ST_L0_PEND];
	assign take1 = stat_r[ST_GIE] && stat_r[ST_L1_EN]
		&& stat_r[ST_L1_PEND];
	assign take2 = stat_r[ST_GIE] && stat_r[ST_L2_EN]
		&& stat_r[ST_L2_PEND];
	// level 0 beats 1 beats 2
	assign take_lvl = take0 ? 2'd0 : (take1 ? 2'd1 : 2'd2);
	// taken only at an instruction boundary or from halt
	assign irq_take = (take0 || take1 || take2)
		&& (instr_valid || halted_r);
	assign ev_wake = stat_r[ST_LOW_EV] || stat_r[ST_HIGH_EV];
	assign exec = instr_valid && !halted_r && !irq_take && !op_bad;

	// single-cycle execute
	always_comb begin
		pc_nxt = pc_r;
		halt_nxt = halted_r;
		res = 8'h00;
		acc_val = 8'h00;
		sum9 = 9'h000;
		prod = 16'h0000;
		c_nxt = c_r;
		v_nxt = v_r;
		upd_z = 1'b0;
		wr_r1 = 1'b0;
		wr_acc = 1'b0;
		wr_ip = 1'b0;
		ip_val = 16'h0000;
		push = 1'b0;
		pop = 1'b0;
		push_val = 16'h0000;
		set_gie = 1'b0;
		dm_we = 1'b0;
		dm_re = 1'b0;
		if (irq_take) begin
			push = 1'b1;
			push_val = pc_r;
			pc_nxt = IRQ_VECTOR;
			halt_nxt = 1'b0;
		end else if (halted_r) begin
			// event resumes at the word after halt
			if (ev_wake) begin
				halt_nxt = 1'b0;
			end
		end else if (instr_valid) begin
			pc_nxt = pc_inc;
			case (op)
				OP_JUMP: pc_nxt = jaddr;
				OP_JUMPIP: pc_nxt = ip_w;
				OP_JZ: pc_nxt = z_r ? jaddr : pc_inc;
				OP_JNZ: pc_nxt = z_r ? pc_inc : jaddr;
				OP_JC: pc_nxt = c_r ? jaddr : pc_inc;
				OP_JNC: pc_nxt = c_r ? pc_inc : jaddr;
				OP_CALL: begin
					push = 1'b1;
					push_val = pc_inc;
					pc_nxt = jaddr;
				end
				OP_CALLS: begin
					wr_ip = 1'b1;
					ip_val = pc_inc;
					pc_nxt = jaddr;
				end
				OP_RET: begin
					pop = 1'b1;
					pc_nxt = stack_r[0];
				end
				OP_RETS: pc_nxt = ip_w;
				OP_RETI: begin
					pop = 1'b1;
					pc_nxt = stack_r[0];
					set_gie = 1'b1;
				end
				OP_PUSH: begin
					push = 1'b1;
					push_val = ip_w;
				end
				OP_POP: begin
					pop = 1'b1;
					wr_ip = 1'b1;
					ip_val = stack_r[0];
				end
				OP_HALT: halt_nxt = 1'b1;
				OP_NOP: pc_nxt = pc_inc;
				OP_MOVEM: dm_we = 1'b1;
				default: begin
					dm_re = is_mem;
					wr_r1 = 1'b1;
					wr_acc = 1'b1;
					upd_z = 1'b1;
					res = src;
					case (op)
						OP_CMVD: wr_r1 = !c_r;
						OP_CMVS: wr_r1 = c_r;
						OP_SHL: res = {src[6:0], 1'b0};
						OP_SHLC: res = {src[6:0], c_r};
						OP_SHR: res = {1'b0, src[7:1]};
						OP_SHRC: res = {c_r, src[7:1]};
						OP_SHRA: res = {src[7], src[7:1]};
						OP_CPL1: res = ~src;
						OP_CPL2: begin
							res = 8'(~src + 8'h01);
							c_nxt = (res == 8'h00);
							v_nxt = (src == 8'h80);
						end
						OP_INC: begin
							res = 8'(src + 8'h01);
							c_nxt = (res == 8'h00);
							v_nxt = (src == 8'h7F);
						end
						OP_INCC: begin
							res = 8'(src + {7'h00, c_r});
							c_nxt = (res == 8'h00) && c_r;
							v_nxt = c_r && (src == 8'h7F);
						end
						OP_DEC: begin
							res = 8'(src - 8'h01);
							c_nxt = (res != 8'hFF);
							v_nxt = (src == 8'h80);
						end
						OP_ADD: begin
							sum9 = {1'b0, op1} + {1'b0, src};
							res = sum9[7:0];
							c_nxt = sum9[8];
							v_nxt = (op1[7] == src[7])
								&& (res[7] != op1[7]);
						end
						OP_SUB: begin
							sum9 = {1'b0, op1} - {1'b0, src};
							res = sum9[7:0];
							c_nxt = !sum9[8];
							v_nxt = (op1[7] != src[7])
								&& (res[7] != op1[7]);
						end
						OP_AND: res = op1 & src;
						OP_OR: res = op1 | src;
						OP_XOR: res = op1 ^ src;
						OP_MUL: begin
							// high byte to the named register, low to acc
							prod = op1 * src;
							res = prod[15:8];
						end
						default: res = src;
					endcase
					acc_val = (op == OP_MUL) ? prod[7:0] : res;
					if ((op >= OP_SHL) && (op <= OP_SHRA)) begin
						c_nxt = (op >= OP_SHR) ? src[0] : src[7];
						v_nxt = res[7] ^ src[7];
					end
				end
			endcase
		end
	end

	assign dmem.addr = eaddr;
	assign dmem.wdata = op1;
	assign dmem.we = exec && dm_we;
	assign dmem.re = exec && dm_re;

	// apb decode
	always_comb begin
		apb_hit = 1'b1;
		rd_val = 32'h0000_0000;
		if (paddr[1:0] != 2'b00) begin
			apb_hit = 1'b0;
		end else if (paddr < OFS_FLAGS) begin
			rd_val[7:0] = reg_rd(paddr[5:2]);
		end else if (paddr == OFS_FLAGS) begin
			rd_val[FL_Z] = z_r;
			rd_val[FL_C] = c_r;
			rd_val[FL_V] = v_r;
		end else if (paddr == OFS_PC) begin
			rd_val[15:0] = pc_r;
		end else if (paddr == OFS_STATE) begin
			rd_val[SB_HALT] = halted_r;
			rd_val[SB_DEPTH_LSB +: 4] = depth_r;
		end else begin
			apb_hit = 1'b0;
		end
	end
	assign apb_wr = psel && penable && pwrite && apb_hit;
	assign apb_reg_wr = apb_wr && (paddr < OFS_FLAGS);
	assign apb_flag_wr = apb_wr && (paddr == OFS_FLAGS);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !apb_hit;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= rd_val;
		end
	end

	// register file; software writes land after the core's
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_r[i] <= REG_RESET;
			end
		end else begin
			if (exec && wr_r1 && (instr.r1 != REG_STAT)) begin
				regs_r[instr.r1] <= res;
			end
			if (exec && wr_acc) begin
				regs_r[REG_ACC] <= acc_val;
			end
			if (exec && wr_ip) begin
				regs_r[REG_IPH] <= ip_val[15:8];
				regs_r[REG_IPL] <= ip_val[7:0];
			end
			if (apb_reg_wr && (paddr[5:2] != REG_STAT)) begin
				regs_r[paddr[5:2]] <= pwdata[7:0];
			end
		end
	end

	// flags word: request sets override any clearing write
	always_comb begin
		stat_nxt = stat_r;
		if (exec && wr_r1 && (instr.r1 == REG_STAT)) begin
			stat_nxt = res;
		end
		if (apb_reg_wr && (paddr[5:2] == REG_STAT)) begin
			stat_nxt = pwdata[7:0];
		end
		if (exec && set_gie) begin
			stat_nxt[ST_GIE] = 1'b1;
		end
		if (irq_take) begin
			stat_nxt[ST_GIE] = 1'b0;
		end
		if (req.irq_low) stat_nxt[ST_L2_PEND] = 1'b1;
		if (req.irq_mid) stat_nxt[ST_L1_PEND] = 1'b1;
		if (req.irq_high) stat_nxt[ST_L0_PEND] = 1'b1;
		if (req.evt_low) stat_nxt[ST_LOW_EV] = 1'b1;
		if (req.evt_high) stat_nxt[ST_HIGH_EV] = 1'b1;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			stat_r <= STAT_RESET;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// condition flags
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			z_r <= 1'b0;
			c_r <= 1'b0;
			v_r <= 1'b0;
		end else if (apb_flag_wr) begin
			z_r <= pwdata[FL_Z];
			c_r <= pwdata[FL_C];
			v_r <= pwdata[FL_V];
		end else if (exec) begin
			if (upd_z) begin
				z_r <= (acc_val == 8'h00);
			end
			c_r <= c_nxt;
			v_r <= v_nxt;
		end
	end

	// program counter and halt
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pc_r <= RESET_PC;
			halted_r <= 1'b0;
			illegal_r <= 1'b0;
			fast_r <= 1'b0;
		end else begin
			pc_r <= pc_nxt & pc_mask;
			halted_r <= halt_nxt;
			illegal_r <= instr_valid && !halted_r && !irq_take && op_bad;
			fast_r <= !sel_sync_r;
		end
	end

	// return stack; a push when full drops the oldest entry
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_r[i] <= 16'h0000;
			end
			depth_r <= 4'h0;
		end else if (push && (irq_take || exec)) begin
			stack_r[0] <= push_val;
			for (int i = 1; i < STACK_DEPTH; i++) begin
				stack_r[i] <= stack_r[i-1];
			end
			if (depth_r != 4'(STACK_DEPTH)) depth_r <= depth_r + 4'h1;
		end else if (pop && exec) begin
			for (int i = 0; i < STACK_DEPTH - 1; i++) begin
				stack_r[i] <= stack_r[i+1];
			end
			stack_r[STACK_DEPTH-1] <= 16'h0000;
			if (depth_r != 4'h0) depth_r <= depth_r - 4'h1;
		end
	end

	assign program_counter = pc_r;
	assign prdata = prdata_r;
	assign halted = halted_r;
	assign illegal_op = illegal_r;
	assign fast_fetch = fast_r;

	chk_irq_entry: assert property (@(posedge clock) disable iff (!nrst)
		irq_take |=> pc_r == IRQ_VECTOR && !stat_r[ST_GIE]
		&& stack_r[0] == $past(pc_r))
		else $error("interrupt entry wrong");
	// with the global enable off, pending requests alone never wake halt
	chk_gie_gate: assert property (@(posedge clock) disable iff (!nrst)
		halted_r && !stat_r[ST_GIE] && !ev_wake |=> halted_r)
		else $error("halt left with global enable off");
	chk_l2_gate: assert property (@(posedge clock) disable iff (!nrst)
		irq_take && take_lvl == 2'd2 |-> stat_r[ST_L2_EN])
		else $error("level 2 taken while disabled");
	chk_l1_gate: assert property (@(posedge clock) disable iff (!nrst)
		irq_take && take_lvl == 2'd1 |-> stat_r[ST_L1_EN])
		else $error("level 1 taken while disabled");
	chk_level_prio: assert property (@(posedge clock) disable iff (!nrst)
		irq_take && stat_r[ST_L0_PEND] |-> take_lvl == 2'd0)
		else $error("level 0 not served first");
	chk_pend_set: assert property (@(posedge clock) disable iff (!nrst)
		req.irq_high ##0 req.irq_mid ##0 req.irq_low |=>
		stat_r[4:2] == 3'b111)
		else $error("interrupt request lost");
	chk_event_set: assert property (@(posedge clock) disable iff (!nrst)
		req.evt_low && req.evt_high |=> stat_r[1:0] == 2'b11)
		else $error("event request lost");
	chk_pend_hold: assert property (@(posedge clock) disable iff (!nrst)
		stat_r[ST_L0_PEND] && !apb_reg_wr && !(exec && wr_r1)
		|=> stat_r[ST_L0_PEND])
		else $error("pending bit dropped without a write");
	chk_event_wake: assert property (@(posedge clock) disable iff (!nrst)
		halted_r && ev_wake && !irq_take |=> !halted_r
		&& $stable(pc_r))
		else $error("event wake did not resume in place");
	chk_jump_once: assert property (@(posedge clock) disable iff (!nrst)
		exec && op == OP_JUMP |=> pc_r == ($past(jaddr) & $past(pc_mask)))
		else $error("jump not done in one cycle");
	chk_zero_flag: assert property (@(posedge clock) disable iff (!nrst)
		exec && upd_z && !apb_flag_wr && !apb_reg_wr |=>
		z_r == (regs_r[REG_ACC] == 8'h00))
		else $error("zero flag disagrees with accumulator");
	chk_fetch_space: assert property (@(posedge clock) disable iff (!nrst)
		!sel_sync_r |=> (pc_r & ~SHORT_PC_MASK) == 16'h0000)
		else $error("program counter beyond short space");
endmodule : rcr_core_regs

// ==== hw/rcr_pkg.sv ====
package rcr_pkg;
	// core widths
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam int NUM_REGS = 16;
	localparam int INSTR_W = 22;
	localparam int OP_COUNT = 35;
	localparam int MODE_COUNT = 8;
	localparam int STACK_DEPTH = 8;
	// program space: 8k instructions full, 4k in fast fetch
	localparam logic [15:0] FULL_PC_MASK = 16'h1FFF;
	localparam logic [15:0] SHORT_PC_MASK = 16'h0FFF;
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [15:0] IRQ_VECTOR = 16'h0001;
	// internal register indices
	localparam logic [3:0] REG_R0 = 4'h0;
	localparam logic [3:0] REG_DATA_OFS = 4'h3;
	localparam logic [3:0] REG_I0H = 4'h4;
	localparam logic [3:0] REG_I0L = 4'h5;
	localparam logic [3:0] REG_I1H = 4'h6;
	localparam logic [3:0] REG_I1L = 4'h7;
	localparam logic [3:0] REG_I2H = 4'h8;
	localparam logic [3:0] REG_I2L = 4'h9;
	localparam logic [3:0] REG_I3H = 4'hA;
	localparam logic [3:0] REG_I3L = 4'hB;
	localparam logic [3:0] REG_IPH = 4'hC;
	localparam logic [3:0] REG_IPL = 4'hD;
	localparam logic [3:0] REG_STAT = 4'hE;
	localparam logic [3:0] REG_ACC = 4'hF;
	// core_flags_word bit positions
	localparam int ST_L2_EN = 7;
	localparam int ST_L1_EN = 6;
	localparam int ST_GIE = 5;
	localparam int ST_L2_PEND = 4;
	localparam int ST_L1_PEND = 3;
	localparam int ST_L0_PEND = 2;
	localparam int ST_LOW_EV = 1;
	localparam int ST_HIGH_EV = 0;
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	// apb map
	localparam logic [11:0] OFS_REGS = 12'h000;
	localparam logic [11:0] OFS_FLAGS = 12'h040;
	localparam logic [11:0] OFS_PC = 12'h044;
	localparam logic [11:0] OFS_STATE = 12'h048;
	localparam int FL_Z = 0;
	localparam int FL_C = 1;
	localparam int FL_V = 2;
	localparam int SB_HALT = 0;
	localparam int SB_DEPTH_LSB = 8;

	typedef enum logic [5:0] {
		OP_NOP, OP_JUMP, OP_JUMPIP, OP_JZ, OP_JNZ, OP_JC, OP_JNC,
		OP_CALL, OP_CALLS, OP_RET, OP_RETS, OP_RETI, OP_PUSH, OP_POP,
		OP_HALT, OP_MOVE, OP_MOVEM, OP_CMVD, OP_CMVS, OP_SHL, OP_SHLC,
		OP_SHR, OP_SHRC, OP_SHRA, OP_CPL1, OP_CPL2, OP_INC, OP_INCC,
		OP_DEC, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_MUL
	} rcr_op_type;

	typedef enum logic [2:0] {
		MD_IMM, MD_REG, MD_IDX0, MD_IDX1, MD_IDX2, MD_IDX3,
		MD_IDX0_OFS, MD_DIRECT
	} rcr_mode_type;

	// 22-bit word; jumps take their target from the low 16 bits
	typedef struct packed {
		logic [5:0] op;
		logic spare;
		logic [2:0] mode;
		logic [3:0] r1;
		logic [7:0] data;
	} rcr_instr_type;

	typedef struct packed {
		logic irq_low;
		logic irq_mid;
		logic irq_high;
		logic evt_low;
		logic evt_high;
	} rcr_req_type;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} rcr_dmem_type;
endpackage : rcr_pkg

// ==== verif/rcr_mem_model.sv ====
`timescale 1ns/1ps
module rcr_mem_model (
	// clock
	input wire logic clock,
	// program side
	input wire logic [rcr_pkg::WORD_W-1:0] program_counter,
	output rcr_pkg::rcr_instr_type instr,
	output logic instr_valid,
	input wire logic run,
	// data side
	input wire rcr_pkg::rcr_dmem_type dmem,
	output logic [rcr_pkg::DATA_W-1:0] dmem_rdata
);
	import rcr_pkg::*;
	// unloaded words hold the nop encoding
	rcr_instr_type rom [0:8191];
	// unwritten bytes read unknown, as real ram would
	logic [7:0] ram [0:255];
	initial begin
		for (int i = 0; i < 8192; i++) begin
			rom[i] = '0;
		end
	end
	// one full 22-bit word per address
	assign instr = rom[program_counter[12:0]];
	assign instr_valid = run;
	assign dmem_rdata = ram[dmem.addr[7:0]];
	always @(posedge clock) begin
		if (dmem.we === 1'b1) begin
			ram[dmem.addr[7:0]] <= dmem.wdata;
		end
	end
endmodule : rcr_mem_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
	import rcr_pkg::*;
	logic clock;
	logic nrst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [WORD_W-1:0] program_counter;
	rcr_instr_type instr;
	logic instr_valid;
	logic slow_fetch_select;
	logic fast_fetch;
	rcr_dmem_type dmem;
	logic [DATA_W-1:0] dmem_rdata;
	rcr_req_type req;
	logic halted;
	logic illegal_op;
	logic run;
	int bad_count;
	int n_compared;
	logic [31:0] rd;
	logic err;
	logic [31:0] e;
	int n_illegal = 0;

	// the illegal flag stands one cycle, so count it at every edge
	always @(posedge clock) begin
		if (illegal_op === 1'b1) begin
			n_illegal <= n_illegal + 1;
		end
	end

	rcr_core_regs i_dut (.clock(clock), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.program_counter(program_counter), .instr(instr),
		.instr_valid(instr_valid), .slow_fetch_select(slow_fetch_select),
		.fast_fetch(fast_fetch), .dmem(dmem), .dmem_rdata(dmem_rdata),
		.req(req), .halted(halted), .illegal_op(illegal_op));
	rcr_mem_model i_mem (.clock(clock), .program_counter(program_counter),
		.instr(instr), .instr_valid(instr_valid), .run(run), .dmem(dmem),
		.dmem_rdata(dmem_rdata));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	function automatic rcr_instr_type ins(rcr_op_type op, rcr_mode_type md,
		logic [3:0] r, logic [7:0] d);
		ins = {6'(op), 1'b0, 3'(md), r, d};
	endfunction : ins

	function automatic logic [11:0] ofs(logic [3:0] n);
		ofs = OFS_REGS + {6'h00, n, 2'b00};
	endfunction : ofs

	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	task check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			bad_count++;
		end
	endtask : check

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			finish_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	task rd_chk(input string name, input logic [11:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(name, rd, exp);
	endtask : rd_chk

	// bounded wait for the halt state to reach a level
	task wait_lvl(input logic v);
		int n;
		n = 0;
		while (halted !== v && n < 300) begin
			@(posedge clock);
			n++;
		end
		if (n >= 300) begin
			bad_count++;
			finish_test();
		end
	endtask : wait_lvl

	task pulse(input logic [4:0] v);
		@(posedge clock);
		req <= v;
		@(posedge clock);
		req <= '0;
	endtask : pulse

	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		slow_fetch_select = 1'b0;
		req = '0;
		run = 1'b0;
		bad_count = 0;
		n_compared = 0;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		for (int n = 0; n < 16; n++) begin
			rd_chk("reg reset", ofs(4'(n)), 32'h0);
		end
		rd_chk("flags reset", OFS_FLAGS, 32'h0);
		rd_chk("pc reset", OFS_PC, 32'h0);
		check("fast fetch", {31'h0, fast_fetch}, 32'h1);
		apb(1'b1, ofs(4'h2), 32'hFFFFFFA5);
		rd_chk("r2 write", ofs(4'h2), 32'h000000A5);
		apb(1'b1, OFS_PC, 32'h00001234);
		rd_chk("pc read only", OFS_PC, 32'h0);
		apb(1'b0, 12'h04C, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		check("unmapped data", rd, 32'h0);
		// all requests at once while stopped: every bit must latch
		pulse(5'h1F);
		rd_chk("all requests", ofs(REG_STAT), 32'h1F);
		apb(1'b1, ofs(REG_STAT), 32'h0);
		rd_chk("all cleared", ofs(REG_STAT), 32'h0);
		$display("test reset and bus done");
		// jump to 0x1010 lands at 0x0010 only in the 4k space
		i_mem.rom[0] = ins(OP_JUMP, MD_REG, 4'h0, 8'h10);
		i_mem.rom[1] = ins(OP_MOVE, MD_IMM, REG_STAT, 8'hC0);
		i_mem.rom[2] = ins(OP_RETI, MD_IMM, 4'h0, 8'h00);
		i_mem.rom[16] = ins(OP_MOVE, MD_IMM, 4'h0, 8'hFF);
		i_mem.rom[17] = ins(OP_ADD, MD_IMM, 4'h0, 8'h01);
		i_mem.rom[18] = ins(OP_HALT, MD_IMM, 4'h0, 8'h00);
		// event wake leaves its bit set, so software clears it first
		i_mem.rom[19] = ins(OP_MOVE, MD_IMM, REG_STAT, 8'h00);
		i_mem.rom[20] = ins(OP_MOVE, MD_IMM, 4'h1, 8'h40);
		i_mem.rom[21] = ins(OP_SHL, MD_REG, 4'h1, 8'h01);
		i_mem.rom[22] = ins(OP_MOVE, MD_IMM, REG_STAT, 8'hE0);
		i_mem.rom[23] = ins(OP_HALT, MD_IMM, 4'h0, 8'h00);
		i_mem.rom[24] = ins(OP_HALT, MD_IMM, 4'h0, 8'h00);
		i_mem.rom[25] = ins(OP_MOVE, MD_IMM, REG_STAT, 8'h00);
		i_mem.rom[26] = {6'h3F, 16'h0000};
		i_mem.rom[27] = ins(OP_MOVEM, MD_DIRECT, 4'h1, 8'h33);
		i_mem.rom[28] = ins(OP_MOVE, MD_DIRECT, 4'h2, 8'h33);
		i_mem.rom[29] = ins(OP_HALT, MD_IMM, 4'h0, 8'h00);
		run <= 1'b1;
		wait_lvl(1'b1);
		rd_chk("acc add", ofs(REG_ACC), 32'h0);
		rd_chk("r0 add", ofs(4'h0), 32'h0);
		rd_chk("flags add", OFS_FLAGS, 32'h3);
		rd_chk("pc after halt", OFS_PC, 32'h13);
		$display("test add done");
		e = 32'h0;
		for (int b = 4; b >= 2; b--) begin
			pulse(5'(1 << b));
			e = e | (32'h1 << b);
			rd_chk("irq latch", ofs(REG_STAT), e);
		end
		check("no wake", {31'h0, halted}, 32'h1);
		apb(1'b1, ofs(REG_STAT), 32'h0);
		rd_chk("irq clear", ofs(REG_STAT), 32'h0);
		$display("test pending done");
		pulse(5'h01);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		rd_chk("r1 shift", ofs(4'h1), 32'h80);
		rd_chk("flags shift", OFS_FLAGS, 32'h4);
		rd_chk("acc move", ofs(REG_ACC), 32'hE0);
		rd_chk("pc event", OFS_PC, 32'h18);
		$display("test event done");
		pulse(5'h10);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		rd_chk("pc return", OFS_PC, 32'h19);
		rd_chk("flags reti", ofs(REG_STAT), 32'hE0);
		rd_chk("state", OFS_STATE, 32'h1);
		$display("test interrupt done");
		// all three levels at once: level 0 is taken, then resume at 0x19
		pulse(5'h1C);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		check("illegal pulses", 32'(n_illegal), 32'h1);
		check("ram store", {24'h0, i_mem.ram[8'h33]}, 32'h80);
		rd_chk("r2 load", ofs(4'h2), 32'h80);
		rd_chk("pc after illegal", OFS_PC, 32'h1E);
		rd_chk("flags cleared", ofs(REG_STAT), 32'h0);
		rd_chk("stack empty", OFS_STATE, 32'h1);
		$display("test priority and memory done");
		finish_test();
	end
endmodule : tb
